// ==== core/art_timer.sv ====
// Auto-reload timer with split mode, slow oscillator capture and suspend wake
//
// What this block does
// - Sixteen-bit up-counter built from separately accessible low and high bytes.
// - Sixteen-bit wrap loads reload value and sets the high overflow flag.
// - Sixteen-bit mode requests interrupt on every full overflow when enabled.
// - With low interrupt enable, low byte wrap also requests an interrupt.
// - Split mode runs two independent 8-bit counters, each with own reload.
// - In split mode run bit gates only the high byte.
// - Per-byte select picks system clock, else field picks /12, ext/8, slow/8.
// - Split mode sets each byte's overflow flag on its own wrap.
// - Split mode interrupts on high overflow, or either with low enable.
// - Overflow flags are never cleared by hardware; software clears them.
// - Slow sources are synchronised except in suspend, where they drive directly.
// - Timer counts during suspend and its overflow wakes the device.
// - After other wake-up, sync pending reads 1 for up to three timer clocks.
// - Capture mode copies counter into reload on slow falling edge, sets high flag.
// - Capture mode with interrupt enabled interrupts on each slow falling edge.
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "art_defs.svh"
module art_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic irq_enable,
  input wire logic suspend,
  input wire logic ext_clk,
  input wire logic slow_osc,
  input wire logic lfo_div_one,
  output logic irq_req,
  output logic wake_req,
  output logic sync_pending
);
  import art_pkg::*;

  logic tf_h_q, tf_l_q, low_ie_q, cap_en_q, split_q, run_q;
  art_xsel_t xsel_q;
  logic sys_lo_q, sys_hi_q;
  logic [7:0] rl_lo_q, rl_hi_q;
  logic [31:0] prdata_q;
  logic slverr_q;
  logic wake_q;
  art_sync_st_t st_q, st_d;
  logic [1:0] wcnt_q, wcnt_d;
  logic woke_q;

  wire logic tick_lo, tick_hi, slow_fall;
  wire logic [1:0] at_max;
  wire logic [7:0] cnt [2];
  wire logic [1:0] en_b, rl_b, wr_b;
  wire logic [7:0] rlv [2];
  wire logic setup, access, wr_acc;
  wire logic wr_ctrl, wr_cklo, wr_ckhi, wr_rllo, wr_rlhi, wr_cksel;
  wire logic mapped;
  wire logic full_max, ovf_lo, ovf_hi, cap_ev, tmr_ovf;
  wire logic [7:0] ctrl_rd;
  wire logic [31:0] rd_mux;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return (a == off);
  endfunction : hit

  // APB decode; zero wait state, read data latched in the setup cycle
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr_acc = access & pwrite;
  assign wr_ctrl = wr_acc & hit(paddr, `ART_OFF_CTRL);
  assign wr_cklo = wr_acc & hit(paddr, `ART_OFF_CNT_LO);
  assign wr_ckhi = wr_acc & hit(paddr, `ART_OFF_CNT_HI);
  assign wr_rllo = wr_acc & hit(paddr, `ART_OFF_RL_LO);
  assign wr_rlhi = wr_acc & hit(paddr, `ART_OFF_RL_HI);
  assign wr_cksel = wr_acc & hit(paddr, `ART_OFF_CKSEL);
  assign mapped = hit(paddr, `ART_OFF_CTRL) | hit(paddr, `ART_OFF_CNT_LO) |
                  hit(paddr, `ART_OFF_CNT_HI) | hit(paddr, `ART_OFF_RL_LO) |
                  hit(paddr, `ART_OFF_RL_HI) | hit(paddr, `ART_OFF_CKSEL) |
                  hit(paddr, `ART_OFF_STAT);
  assign ctrl_rd = {tf_h_q, tf_l_q, low_ie_q, cap_en_q, split_q, run_q, xsel_q};
  assign rd_mux = hit(paddr, `ART_OFF_CTRL) ? {24'h000000, ctrl_rd} :
                  hit(paddr, `ART_OFF_CNT_LO) ? {24'h000000, cnt[0]} :
                  hit(paddr, `ART_OFF_CNT_HI) ? {24'h000000, cnt[1]} :
                  hit(paddr, `ART_OFF_RL_LO) ? {24'h000000, rl_lo_q} :
                  hit(paddr, `ART_OFF_RL_HI) ? {24'h000000, rl_hi_q} :
                  hit(paddr, `ART_OFF_CKSEL) ? {30'h0000000, sys_hi_q, sys_lo_q} :
                  hit(paddr, `ART_OFF_STAT) ? {31'h0000000, sync_pending} : 32'h00000000;
  assign pready = access;
  assign pslverr = access & slverr_q;
  assign prdata = prdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
      slverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h00000000 : rd_mux;
      slverr_q <= ~mapped;
    end
  end

  art_clk_src u_clk (
    .pclk(pclk),
    .presetn(presetn),
    .suspend(suspend),
    .ext_clk(ext_clk),
    .slow_osc(slow_osc),
    .lfo_div_one(lfo_div_one),
    .xsel(xsel_q),
    .sys_lo(sys_lo_q),
    .sys_hi(sys_hi_q),
    .tick_lo(tick_lo),
    .tick_hi(tick_hi),
    .slow_fall(slow_fall)
  );

  // Sixteen-bit mode chains the high byte on the low byte's carry
  assign full_max = at_max[0] & at_max[1];
  assign en_b[0] = split_q ? tick_lo : (tick_lo & run_q);
  assign en_b[1] = split_q ? (tick_hi & run_q) : (tick_lo & run_q & at_max[0]);
  assign rl_b[0] = split_q ? at_max[0] : full_max;
  assign rl_b[1] = split_q ? at_max[1] : full_max;
  assign wr_b = {wr_ckhi, wr_cklo};
  assign rlv[0] = rl_lo_q;
  assign rlv[1] = rl_hi_q;
  assign ovf_lo = en_b[0] & at_max[0];
  assign ovf_hi = en_b[1] & at_max[1];
  assign cap_ev = cap_en_q & slow_fall;
  assign tmr_ovf = ovf_hi | (split_q & ovf_lo);

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_byte
      art_byte_cnt u_byte (
        .pclk(pclk),
        .presetn(presetn),
        .en(en_b[gi]),
        .reload_now(rl_b[gi]),
        .reload_val(rlv[gi]),
        .wr(wr_b[gi]),
        .wr_data(pwdata[7:0]),
        .cnt_q(cnt[gi]),
        .at_max(at_max[gi])
      );
    end
  endgenerate

  // Flags: a hardware set beats a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tf_h_q <= `ART_RST_BIT;
      tf_l_q <= `ART_RST_BIT;
    end else begin
      tf_h_q <= (ovf_hi | cap_ev) | (wr_ctrl ? pwdata[`ART_BIT_TF_H] : tf_h_q);
      tf_l_q <= ovf_lo | (wr_ctrl ? pwdata[`ART_BIT_TF_L] : tf_l_q);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {low_ie_q, cap_en_q, split_q, run_q} <= 4'h0;
      xsel_q <= XS_SYS12;
      {sys_hi_q, sys_lo_q} <= 2'h0;
    end else begin
      if (wr_ctrl) begin
        low_ie_q <= pwdata[`ART_BIT_LOW_IE];
        cap_en_q <= pwdata[`ART_BIT_CAP_EN];
        split_q <= pwdata[`ART_BIT_SPLIT];
        run_q <= pwdata[`ART_BIT_RUN];
        xsel_q <= art_xsel_t'(pwdata[`ART_BIT_XSEL_HI:`ART_BIT_XSEL_LO]);
      end
      if (wr_cksel) begin
        sys_lo_q <= pwdata[`ART_BIT_SYS_LO];
        sys_hi_q <= pwdata[`ART_BIT_SYS_HI];
      end
    end
  end

  // Capture beats a software write to the reload bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rl_lo_q <= `ART_RST_BYTE;
      rl_hi_q <= `ART_RST_BYTE;
    end else if (cap_ev) begin
      rl_lo_q <= cnt[0];
      rl_hi_q <= cnt[1];
    end else begin
      if (wr_rllo) rl_lo_q <= pwdata[7:0];
      if (wr_rlhi) rl_hi_q <= pwdata[7:0];
    end
  end

  // Level request; software clears the flags to drop it
  assign irq_req = irq_enable & (tf_h_q | (low_ie_q & tf_l_q));

  // Suspend tracking for wake-up and the sync pending window
  always_comb begin
    st_d = st_q;
    wcnt_d = wcnt_q;
    case (st_q)
      ST_IDLE: if (suspend) st_d = ST_SUSP;
      ST_SUSP: begin
        if (!suspend) begin
          st_d = (woke_q | tmr_ovf) ? ST_IDLE : ST_WAIT;
          wcnt_d = 2'h0;
        end
      end
      ST_WAIT: begin
        if (suspend) begin
          st_d = ST_SUSP;
        end else if (tick_lo | tick_hi) begin
          wcnt_d = wcnt_q + 2'h1;
          if (wcnt_d == `ART_SYNC_TICKS) st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      wcnt_q <= 2'h0;
      woke_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      st_q <= st_d;
      wcnt_q <= wcnt_d;
      woke_q <= (st_q == ST_SUSP) & (woke_q | tmr_ovf);
      wake_q <= suspend & tmr_ovf;
    end
  end

  assign wake_req = wake_q;
  assign sync_pending = (st_q == ST_WAIT);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_cap;
    cap_ev && !wr_rllo && !wr_rlhi;
  endsequence
  sequence s_cap_done;
    tf_h_q && rl_lo_q == $past(cnt[0]) && rl_hi_q == $past(cnt[1]);
  endsequence

  property p_ovf16;
    !split_q && tick_lo && run_q && full_max && !wr_cklo && !wr_ckhi
      |=> {cnt[1], cnt[0]} == $past({rl_hi_q, rl_lo_q}) && tf_h_q;
  endproperty
  a_ovf16: assert property (p_ovf16) else $error("16-bit wrap did not reload");

  property p_irq16;
    irq_enable && !split_q && ovf_hi |=> irq_req || !irq_enable;
  endproperty
  a_irq16: assert property (p_irq16) else $error("overflow interrupt missing");

  property p_irq_low;
    irq_enable && low_ie_q && ovf_lo |=> irq_req || !irq_enable || !low_ie_q;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("low byte interrupt missing");

  property p_split_low;
    split_q && tick_lo && !at_max[0] && !wr_cklo |=> cnt[0] == $past(cnt[0]) + 8'h01;
  endproperty
  a_split_low: assert property (p_split_low) else $error("split low byte stalled");

  property p_split_hi_gate;
    split_q && !run_q && !wr_ckhi |=> cnt[1] == $past(cnt[1]);
  endproperty
  a_split_hi_gate: assert property (p_split_hi_gate) else $error("high byte ran");

  property p_split_flag;
    split_q && tick_hi && run_q && at_max[1] && !wr_ckhi
      |=> tf_h_q && cnt[1] == $past(rl_hi_q);
  endproperty
  a_split_flag: assert property (p_split_flag) else $error("high byte wrap lost");

  property p_keep_flag;
    tf_l_q && !wr_ctrl |=> tf_l_q;
  endproperty
  a_keep_flag: assert property (p_keep_flag) else $error("flag cleared by hardware");

  property p_capture;
    s_cap |=> s_cap_done;
  endproperty
  a_capture: assert property (p_capture) else $error("capture not taken");

  property p_cap_irq;
    cap_ev && irq_enable |=> irq_req || $past(wr_ctrl) || !irq_enable;
  endproperty
  a_cap_irq: assert property (p_cap_irq) else $error("capture interrupt missing");

  property p_wake;
    suspend && tmr_ovf |=> wake_req;
  endproperty
  a_wake: assert property (p_wake) else $error("suspend overflow gave no wake");

  property p_sync_bound;
    sync_pending |-> wcnt_q < `ART_SYNC_TICKS;
  endproperty
  a_sync_bound: assert property (p_sync_bound) else $error("sync window too long");
endmodule : art_timer
`default_nettype wire

// ==== core/art_defs.svh ====
// Register offsets, field positions, reset values and counts of the reload timer
`ifndef ART_DEFS_SVH
`define ART_DEFS_SVH

`define ART_OFF_CTRL 8'h00
`define ART_OFF_CNT_LO 8'h04
`define ART_OFF_CNT_HI 8'h08
`define ART_OFF_RL_LO 8'h0C
`define ART_OFF_RL_HI 8'h10
`define ART_OFF_CKSEL 8'h14
`define ART_OFF_STAT 8'h18

`define ART_BIT_TF_H 7
`define ART_BIT_TF_L 6
`define ART_BIT_LOW_IE 5
`define ART_BIT_CAP_EN 4
`define ART_BIT_SPLIT 3
`define ART_BIT_RUN 2
`define ART_BIT_XSEL_HI 1
`define ART_BIT_XSEL_LO 0
`define ART_BIT_SYS_LO 0
`define ART_BIT_SYS_HI 1
`define ART_BIT_SYNC 0

`define ART_RST_BYTE 8'h00
`define ART_RST_BIT 1'b0
`define ART_DIV12_LAST 4'hB
`define ART_DIV8_LAST 3'h7
`define ART_SYNC_TICKS 2'h3

`endif

// ==== core/art_pkg.sv ====
// Types shared by the reload timer modules
package art_pkg;
  typedef enum logic [1:0] {
    XS_SYS12 = 2'h0,
    XS_EXT8 = 2'h1,
    XS_RSVD = 2'h2,
    XS_LFO8 = 2'h3
  } art_xsel_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SUSP = 3'b010,
    ST_WAIT = 3'b100
  } art_sync_st_t;
endpackage : art_pkg

// ==== core/art_clk_src.sv ====
// Timer clock sources: divide-by-12, external and slow oscillator ticks
`timescale 1ns/10ps
`default_nettype none
`include "art_defs.svh"
module art_clk_src (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic suspend,
  input wire logic ext_clk,
  input wire logic slow_osc,
  input wire logic lfo_div_one,
  input wire art_pkg::art_xsel_t xsel,
  input wire logic sys_lo,
  input wire logic sys_hi,
  output logic tick_lo,
  output logic tick_hi,
  output logic slow_fall
);
  import art_pkg::*;

  logic [3:0] div12_q;
  logic [2:0] ediv_q;
  logic [2:0] ldiv_q;
  logic e1_q, e2_q, e3_q, eraw_q;
  logic l1_q, l2_q, l3_q, lraw_q;
  wire logic ext_rise;
  wire logic lfo_rise;
  wire logic s12;
  wire logic e8;
  wire logic l8;

  function automatic logic src_tick(input logic sel_sys, input art_xsel_t xs,
                                    input logic t12, input logic te8, input logic tl8);
    logic t;
    t = 1'b0;
    if (sel_sys) begin
      t = 1'b1;
    end else begin
      case (xs)
        XS_SYS12: t = t12;
        XS_EXT8: t = te8;
        XS_LFO8: t = tl8;
        default: t = 1'b0;
      endcase
    end
    return t;
  endfunction : src_tick

  // In suspend the raw pin drives the count directly, skipping the synchroniser delay
  assign ext_rise = suspend ? (ext_clk & ~eraw_q) : (e2_q & ~e3_q);
  assign lfo_rise = suspend ? (slow_osc & ~lraw_q) : (l2_q & ~l3_q);
  assign slow_fall = suspend ? (~slow_osc & lraw_q) : (~l2_q & l3_q);
  assign s12 = (div12_q == `ART_DIV12_LAST);
  assign e8 = ext_rise & (ediv_q == `ART_DIV8_LAST);
  // Slow source stays silent unless its divider is set to one
  assign l8 = lfo_rise & (ldiv_q == `ART_DIV8_LAST) & lfo_div_one;
  assign tick_lo = src_tick(sys_lo, xsel, s12, e8, l8);
  assign tick_hi = src_tick(sys_hi, xsel, s12, e8, l8);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {e1_q, e2_q, e3_q, eraw_q} <= 4'h0;
      {l1_q, l2_q, l3_q, lraw_q} <= 4'h0;
    end else begin
      {e1_q, e2_q, e3_q, eraw_q} <= {ext_clk, e1_q, e2_q, ext_clk};
      {l1_q, l2_q, l3_q, lraw_q} <= {slow_osc, l1_q, l2_q, slow_osc};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div12_q <= 4'h0;
      ediv_q <= 3'h0;
      ldiv_q <= 3'h0;
    end else begin
      div12_q <= s12 ? 4'h0 : div12_q + 4'h1;
      if (ext_rise) ediv_q <= ediv_q + 3'h1;
      if (lfo_rise) ldiv_q <= ldiv_q + 3'h1;
    end
  end
endmodule : art_clk_src
`default_nettype wire

// ==== core/art_byte_cnt.sv ====
// One 8-bit up-counter byte with reload and software load
`timescale 1ns/10ps
`default_nettype none
`include "art_defs.svh"
module art_byte_cnt (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic reload_now,
  input wire logic [7:0] reload_val,
  input wire logic wr,
  input wire logic [7:0] wr_data,
  output logic [7:0] cnt_q,
  output logic at_max
);
  assign at_max = (cnt_q == 8'hFF);

  // Software load wins over a count in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= `ART_RST_BYTE;
    end else if (wr) begin
      cnt_q <= wr_data;
    end else if (en) begin
      cnt_q <= reload_now ? reload_val : cnt_q + 8'h01;
    end
  end
endmodule : art_byte_cnt
`default_nettype wire

// ==== verif/art_timer_tb_top.sv ====
// Self-checking bench for the auto-reload timer
`timescale 1ns/10ps
`default_nettype none
`include "art_defs.svh"
module art_timer_tb_top;
  localparam logic [7:0] ctl = `ART_OFF_CTRL;
  localparam logic [7:0] clo = `ART_OFF_CNT_LO;
  localparam logic [7:0] chi = `ART_OFF_CNT_HI;
  localparam logic [7:0] rlo = `ART_OFF_RL_LO;
  localparam logic [7:0] rhi = `ART_OFF_RL_HI;
  localparam logic [7:0] cks = `ART_OFF_CKSEL;
  localparam logic [7:0] sts = `ART_OFF_STAT;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic irq_enable = 1'b1;
  logic suspend = 1'b0;
  logic ext_clk = 1'b0;
  logic slow_osc = 1'b0;
  logic lfo_div_one = 1'b1;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq_req;
  logic wake_req;
  logic sync_pending;
  int errors = 0;
  int checks_done = 0;
  int wake_seen = 0;
  logic [7:0] rd_q;
  logic err_q;

  always #12.5 pclk = ~pclk;

  art_timer art_timer_i (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .irq_enable(irq_enable),
    .suspend(suspend),
    .ext_clk(ext_clk),
    .slow_osc(slow_osc),
    .lfo_div_one(lfo_div_one),
    .irq_req(irq_req),
    .wake_req(wake_req),
    .sync_pending(sync_pending)
  );

  // Wake is a one-cycle pulse, so it is counted, not polled
  always @(negedge pclk) begin
    if (wake_req === 1'b1) begin
      wake_seen <= wake_seen + 1;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done;
    $display("checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  // Entered just after a rising edge; idle cycle at the end avoids double drive
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge pclk);
    end
    rd_q = prdata[7:0];
    err_q = pslverr;
    if (n == 16) begin
      errors++;
      test_done();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 8'h00);
  endtask : rd

  task automatic toggle(input int n);
    repeat (n) begin
      ext_clk <= ~ext_clk;
      slow_osc <= ~slow_osc;
      repeat (4) @(posedge pclk);
    end
  endtask : toggle

  task automatic t_reset;
    for (int i = 0; i < 7; i++) begin
      rd(8'(i * 4));
      check(rd_q, 8'h00);
    end
    rd(8'h1C);
    check(err_q, 1'b1);
    check(rd_q, 8'h00);
    $display("reset test done");
  endtask : t_reset

  // Select field 10 has no source, used to freeze the count
  task automatic t_carry;
    wr(ctl, 8'h02);
    wr(cks, 8'h00);
    wr(clo, 8'hFF);
    wr(chi, 8'h12);
    rd(clo);
    check(rd_q, 8'hFF);
    rd(chi);
    check(rd_q, 8'h12);
    wr(ctl, 8'h06);
    wr(cks, 8'h01);
    wr(cks, 8'h00);
    rd(chi);
    check(rd_q, 8'h13);
    $display("carry test done");
  endtask : t_carry

  task automatic t_wrap;
    wr(rlo, 8'hFE);
    wr(rhi, 8'hFF);
    wr(clo, 8'hFE);
    wr(chi, 8'hFF);
    wr(ctl, 8'h26);
    wr(cks, 8'h01);
    repeat (6) @(posedge pclk);
    @(negedge pclk);
    check(irq_req, 1'b1);
    @(posedge pclk);
    wr(cks, 8'h00);
    rd(ctl);
    check(rd_q, 8'hE6);
    rd(chi);
    check(rd_q, 8'hFF);
    rd(rlo);
    check(rd_q, 8'hFE);
    irq_enable <= 1'b0;
    repeat (30) @(posedge pclk);
    @(negedge pclk);
    check(irq_req, 1'b0);
    @(posedge pclk);
    irq_enable <= 1'b1;
    rd(ctl);
    check(rd_q, 8'hE6);
    wr(clo, 8'hFE);
    wr(chi, 8'h00);
    wr(ctl, 8'h06);
    wr(cks, 8'h01);
    wr(cks, 8'h00);
    rd(ctl);
    check(rd_q, 8'h46);
    check(irq_req, 1'b0);
    wr(ctl, 8'h66);
    @(negedge pclk);
    check(irq_req, 1'b1);
    @(posedge pclk);
    $display("wrap test done");
  endtask : t_wrap

  task automatic t_split;
    logic [7:0] lo;
    wr(ctl, 8'h2A);
    wr(rlo, 8'hA0);
    wr(rhi, 8'hB0);
    wr(clo, 8'hFF);
    wr(chi, 8'hFF);
    wr(cks, 8'h03);
    wr(cks, 8'h00);
    rd(chi);
    check(rd_q, 8'hFF);
    rd(clo);
    lo = rd_q;
    check(lo >= 8'hA0 && lo <= 8'hA8, 1'b1);
    rd(ctl);
    check(rd_q, 8'h6A);
    check(irq_req, 1'b1);
    wr(ctl, 8'h0E);
    wr(cks, 8'h02);
    wr(cks, 8'h00);
    rd(chi);
    check(rd_q >= 8'hB0 && rd_q <= 8'hB8, 1'b1);
    rd(clo);
    check(rd_q, lo);
    rd(ctl);
    check(rd_q, 8'h8E);
    check(irq_req, 1'b1);
    wr(ctl, 8'h4A);
    check(irq_req, 1'b0);
    $display("split test done");
  endtask : t_split

  // One tick of slack, the dividers keep their phase between runs
  task automatic t_src;
    int sel[5] = '{0, 1, 2, 3, 3};
    int tk[5] = '{16, 3, 0, 3, 0};
    for (int k = 0; k < 5; k++) begin
      lfo_div_one <= (k < 4);
      wr(ctl, 8'h02);
      wr(clo, 8'h00);
      wr(chi, 8'h00);
      wr(ctl, 8'h04 | 8'(sel[k]));
      toggle(48);
      wr(ctl, 8'h02);
      rd(clo);
      check(rd_q + 1 >= tk[k] && rd_q <= tk[k] + (k != 2 && k != 4), 1'b1);
    end
    lfo_div_one <= 1'b1;
    $display("clock source test done");
  endtask : t_src

  task automatic t_cap;
    logic [7:0] cnt;
    slow_osc <= 1'b1;
    wr(cks, 8'h00);
    wr(rlo, 8'h00);
    wr(rhi, 8'h00);
    wr(ctl, 8'h16);
    wr(cks, 8'h01);
    repeat (20) @(posedge pclk);
    slow_osc <= 1'b0;
    repeat (6) @(posedge pclk);
    wr(cks, 8'h00);
    check(irq_req, 1'b1);
    rd(ctl);
    check(rd_q, 8'h96);
    rd(clo);
    cnt = rd_q;
    rd(rlo);
    check(rd_q >= 8'h14 && rd_q < cnt && cnt - rd_q < 8'h10, 1'b1);
    $display("capture test done");
  endtask : t_cap

  task automatic t_susp;
    check(wake_seen, 0);
    wr(ctl, 8'h02);
    wr(clo, 8'hFE);
    wr(chi, 8'hFF);
    wr(ctl, 8'h05);
    suspend <= 1'b1;
    toggle(48);
    check(wake_seen >= 1, 1'b1);
    suspend <= 1'b0;
    $display("suspend test done");
  endtask : t_susp

  task automatic t_sync;
    wr(ctl, 8'h04);
    wr(clo, 8'h00);
    wr(chi, 8'h00);
    suspend <= 1'b1;
    repeat (10) @(posedge pclk);
    suspend <= 1'b0;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    check(sync_pending, 1'b1);
    repeat (60) @(posedge pclk);
    rd(sts);
    check(rd_q, 8'h00);
    check(sync_pending, 1'b0);
    $display("sync test done");
  endtask : t_sync

  // Whole run is about 1600 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    test_done();
  end

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_carry();
    t_wrap();
    t_split();
    t_src();
    t_cap();
    t_susp();
    t_sync();
    test_done();
  end
endmodule : art_timer_tb_top
`default_nettype wire
